// >>> design/tdi_defines.svh
`ifndef TDI_DEFINES_SVH
`define TDI_DEFINES_SVH

// ------------------------------------------------------------
// Register map (byte addresses)
// ------------------------------------------------------------
`define TDI_OFS_CTRL 12'h000
`define TDI_OFS_HEAD 12'h004
`define TDI_OFS_STAT 12'h008
`define TDI_OFS_MASK 12'h00c
`define TDI_OFS_RXCNT 12'h010
`define TDI_OFS_CUR 12'h014
`define TDI_OFS_STATE 12'h018

// ------------------------------------------------------------
// Descriptor layout
// ------------------------------------------------------------
`define TDI_W_NEXT 2'h0
`define TDI_W_BUF 2'h1
`define TDI_W_LEN 2'h2
`define TDI_W_CTRL 2'h3
`define TDI_CTRL_BYTE_OFS 32'h0000_000c
`define TDI_WORD_STEP 32'h0000_0004
`define TDI_BIT_FIRST 31
`define TDI_BIT_LAST 30
`define TDI_BIT_OWN 29
`define TDI_BIT_DRAIN 28
`define TDI_BIT_ZERO 23
`define TDI_BIT_RXABORT 19

// ------------------------------------------------------------
// Interrupt status bits and reset values
// ------------------------------------------------------------
`define TDI_ST_PKT 0
`define TDI_ST_DRAIN 1
`define TDI_ST_RXAB 2
`define TDI_ST_W 3
`define TDI_RST_MASK 3'h0
`define TDI_RST_RXCNT 16'h0000

`endif

// >>> design/tdi_engine.sv
`timescale 1ns/1ps
`include "tdi_defines.svh"
module tdi_engine (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // Descriptor and buffer memory
  output tdi_pkg::tdi_mem_cmd_t mem_cmd,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // Endpoint FIFO side
  output tdi_pkg::tdi_beat_t tx_beat,
  input wire logic tx_ready,
  // Receive channel events
  input wire logic rx_drop,
  input wire logic [31:0] rx_desc_addr,
  input wire logic [31:0] rx_desc_ctrl,
  output logic rx_stalled
);

  // Declarations
  tdi_pkg::tdi_state_t state;
  tdi_pkg::tdi_state_t next_state;
  logic run;
  logic [31:0] head;
  logic [`TDI_ST_W-1:0] status;
  logic [`TDI_ST_W-1:0] mask;
  logic [15:0] rx_count;
  logic rx_pend;
  logic [31:0] rx_addr;
  logic [31:0] rx_ctrl;
  logic [31:0] desc [0:3];
  logic [1:0] widx;
  logic [31:0] cur;
  logic [31:0] first_desc;
  logic [31:0] first_ctrl;
  logic [31:0] byte_addr;
  logic [15:0] bytes_left;
  logic [15:0] pkt_left;
  logic [7:0] byte_reg;
  logic zlp_beat;

  // Pick one byte lane of a fetched word
  function automatic logic [7:0] lane(input logic [31:0] w,
                                      input logic [1:0] sel);
    lane = w[8*sel +: 8];
  endfunction

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  wire wr_en = psel && penable && pwrite;
  wire rd_setup = psel && !penable && !pwrite;
  wire hit_ctrl = paddr == `TDI_OFS_CTRL;
  wire hit_head = paddr == `TDI_OFS_HEAD;
  wire hit_stat = paddr == `TDI_OFS_STAT;
  wire hit_mask = paddr == `TDI_OFS_MASK;
  wire hit_rxcnt = paddr == `TDI_OFS_RXCNT;
  wire hit_cur = paddr == `TDI_OFS_CUR;
  wire hit_state = paddr == `TDI_OFS_STATE;
  wire hit_any = hit_ctrl | hit_head | hit_stat | hit_mask | hit_rxcnt |
                 hit_cur | hit_state;
  wire [31:0] rd_mux =
    hit_ctrl ? {31'h0, run} :
    hit_head ? head :
    hit_stat ? {29'h0, status} :
    hit_mask ? {29'h0, mask} :
    hit_rxcnt ? {15'h0, rx_stalled, rx_count} :
    hit_cur ? cur :
    hit_state ? {24'h0, state} : 32'h0;

  // Zero wait states; unmapped addresses flag an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;

  // ------------------------------------------------------------
  // Descriptor field decode (reserved bits never looked at)
  // ------------------------------------------------------------
  wire [31:0] ctrl_w = desc[`TDI_W_CTRL];
  wire is_first = ctrl_w[`TDI_BIT_FIRST];
  wire is_last = ctrl_w[`TDI_BIT_LAST];
  wire is_zero = ctrl_w[`TDI_BIT_ZERO];
  wire [15:0] buf_len = desc[`TDI_W_LEN][15:0];
  wire [15:0] buf_ofs = desc[`TDI_W_LEN][31:16];
  wire [15:0] pkt_len = ctrl_w[15:0];
  wire next_zero = desc[`TDI_W_NEXT] == 32'h0;
  // Packet budget seen in the evaluate cycle
  wire [15:0] eval_pkt = is_first ? pkt_len : pkt_left;

  // Last byte of a packet: budget or final buffer runs out
  wire beat_last = zlp_beat || pkt_left == 16'h0001 ||
                   (is_last && bytes_left == 16'h0001);
  wire buf_end = zlp_beat || bytes_left == 16'h0001 ||
                 pkt_left == 16'h0001;
  wire beat_take = state == tdi_pkg::TDI_OUT && tx_ready;

  // After a buffer: close packet, follow the chain, or stop
  wire tdi_pkg::tdi_state_t after_buf =
    is_last ? tdi_pkg::TDI_OWN :
    next_zero ? tdi_pkg::TDI_IDLE : tdi_pkg::TDI_DESC;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    unique case (state)
      tdi_pkg::TDI_IDLE:
        if (rx_pend)
          next_state = tdi_pkg::TDI_RXAB;
        else if (run && head != 32'h0)
          next_state = tdi_pkg::TDI_DESC;
      tdi_pkg::TDI_DESC:
        if (mem_ack && widx == `TDI_W_CTRL)
          next_state = tdi_pkg::TDI_EVAL;
      tdi_pkg::TDI_EVAL:
        if (is_zero)
          next_state = tdi_pkg::TDI_OUT;
        else if (buf_len == 16'h0 || eval_pkt == 16'h0)
          next_state = after_buf;
        else
          next_state = tdi_pkg::TDI_RD;
      tdi_pkg::TDI_RD:
        if (mem_ack)
          next_state = tdi_pkg::TDI_OUT;
      tdi_pkg::TDI_OUT:
        if (tx_ready)
          next_state = buf_end ? after_buf : tdi_pkg::TDI_RD;
      tdi_pkg::TDI_OWN:
        if (mem_ack)
          next_state = next_zero ? tdi_pkg::TDI_DRAIN : tdi_pkg::TDI_DESC;
      tdi_pkg::TDI_DRAIN:
        if (mem_ack)
          next_state = tdi_pkg::TDI_IDLE;
      tdi_pkg::TDI_RXAB:
        if (mem_ack)
          next_state = tdi_pkg::TDI_IDLE;
      default:
        next_state = tdi_pkg::TDI_IDLE;
    endcase
  end

  // Memory command, driven from registered state
  wire st_desc = state == tdi_pkg::TDI_DESC;
  wire st_rd = state == tdi_pkg::TDI_RD;
  wire st_own = state == tdi_pkg::TDI_OWN;
  wire st_drain = state == tdi_pkg::TDI_DRAIN;
  wire st_rxab = state == tdi_pkg::TDI_RXAB;
  wire [31:0] widx_ofs = {28'h0, widx, 2'b00};

  assign mem_cmd.req = st_desc | st_rd | st_own | st_drain | st_rxab;
  assign mem_cmd.we = st_own | st_drain | st_rxab;
  assign mem_cmd.addr =
    st_desc ? cur + widx_ofs :
    st_rd ? {byte_addr[31:2], 2'b00} :
    st_own ? first_desc + `TDI_CTRL_BYTE_OFS :
    st_drain ? cur + `TDI_CTRL_BYTE_OFS :
    st_rxab ? rx_addr + `TDI_CTRL_BYTE_OFS : 32'h0;
  // Write-backs touch only their flags; drain also frees a lone buffer
  assign mem_cmd.wdata =
    st_own ? first_ctrl & ~(32'h1 << `TDI_BIT_OWN) :
    st_drain ? (ctrl_w & ~(32'(is_first) << `TDI_BIT_OWN)) |
               (32'h1 << `TDI_BIT_DRAIN) :
    st_rxab ? rx_ctrl | (32'h1 << `TDI_BIT_RXABORT) : 32'h0;

  // Beat toward the FIFO; data from flip-flops
  assign tx_beat.valid = state == tdi_pkg::TDI_OUT;
  assign tx_beat.data = byte_reg;
  assign tx_beat.last = state == tdi_pkg::TDI_OUT && beat_last;
  assign tx_beat.zlp = zlp_beat;

  assign irq = |(status & mask);

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= tdi_pkg::TDI_IDLE;
    else
      state <= next_state;
  end

  // Descriptor fetch; all four words kept
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      widx <= 2'h0;
      for (int i = 0; i < 4; i++)
        desc[i] <= 32'h0;
    end
    else if (st_desc && mem_ack)
    begin
      desc[widx] <= mem_rdata;
      widx <= widx + 2'h1;
    end
    else if (!st_desc)
      widx <= 2'h0;
  end

  // Chain walk and byte counters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur <= 32'h0;
      first_desc <= 32'h0;
      first_ctrl <= 32'h0;
      byte_addr <= 32'h0;
      bytes_left <= 16'h0;
      pkt_left <= 16'h0;
      zlp_beat <= 1'b0;
    end
    else
    begin
      if (state == tdi_pkg::TDI_IDLE && next_state == tdi_pkg::TDI_DESC)
        cur <= head;
      else if (next_state == tdi_pkg::TDI_DESC &&
               state != tdi_pkg::TDI_DESC)
        cur <= desc[`TDI_W_NEXT];
      if (state == tdi_pkg::TDI_EVAL)
      begin
        zlp_beat <= is_zero;
        bytes_left <= buf_len;
        pkt_left <= eval_pkt;
        if (is_first)
        begin
          first_desc <= cur;
          first_ctrl <= ctrl_w;
          byte_addr <= desc[`TDI_W_BUF] + {16'h0, buf_ofs};
        end
        else
          byte_addr <= desc[`TDI_W_BUF];
      end
      else if (beat_take && !zlp_beat)
      begin
        byte_addr <= byte_addr + 32'h1;
        bytes_left <= bytes_left - 16'h1;
        pkt_left <= pkt_left - 16'h1;
      end
    end
  end

  // Byte capture, one word read per byte for simplicity
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      byte_reg <= 8'h0;
    else if (st_rd && mem_ack)
      byte_reg <= lane(mem_rdata, byte_addr[1:0]);
    else if (state == tdi_pkg::TDI_EVAL)
      byte_reg <= 8'h0;
  end

  // ------------------------------------------------------------
  // Software registers; a hardware clear of head marks the queue as started
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run <= 1'b0;
      head <= 32'h0;
      mask <= `TDI_RST_MASK;
      prdata <= 32'h0;
    end
    else
    begin
      if (rd_setup)
        prdata <= rd_mux;
      if (wr_en && hit_ctrl)
        run <= pwdata[0];
      if (wr_en && hit_mask)
        mask <= pwdata[`TDI_ST_W-1:0];
      // Head zeroed as the queue starts; written only while idle
      if (state == tdi_pkg::TDI_IDLE && next_state == tdi_pkg::TDI_DESC)
        head <= 32'h0;
      else if (wr_en && hit_head && state == tdi_pkg::TDI_IDLE)
        head <= pwdata;
    end
  end

  // Sticky status, write one to clear; set wins
  wire [`TDI_ST_W-1:0] ev;
  assign ev[`TDI_ST_PKT] = st_own && mem_ack;
  assign ev[`TDI_ST_DRAIN] = st_drain && mem_ack;
  assign ev[`TDI_ST_RXAB] = st_rxab && mem_ack;
  wire [`TDI_ST_W-1:0] w1c = (wr_en && hit_stat) ?
                             pwdata[`TDI_ST_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status <= '0;
    else
      status <= (status & ~w1c) | ev;
  end

  // ------------------------------------------------------------
  // Receive abort: latch the event, stall until refilled
  // ------------------------------------------------------------
  wire rx_hit = rx_drop && rx_count != 16'h0;
  wire cnt_wr = wr_en && hit_rxcnt;
  wire [15:0] cnt_sum = rx_count + pwdata[15:0];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_count <= `TDI_RST_RXCNT;
      rx_stalled <= 1'b0;
      rx_pend <= 1'b0;
      rx_addr <= 32'h0;
      rx_ctrl <= 32'h0;
    end
    else
    begin
      // Drop wins over a software increment in the same cycle
      if (rx_hit)
      begin
        rx_count <= 16'h0;
        rx_stalled <= 1'b1;
        rx_pend <= 1'b1;
        rx_addr <= rx_desc_addr;
        rx_ctrl <= rx_desc_ctrl;
      end
      else
      begin
        if (cnt_wr)
        begin
          rx_count <= cnt_sum;
          if (cnt_sum != 16'h0)
            rx_stalled <= 1'b0;
        end
        if (st_rxab && mem_ack)
          rx_pend <= 1'b0;
      end
    end
  end

endmodule

// >>> design/tdi_pkg.sv
package tdi_pkg;

  // ------------------------------------------------------------
  // Engine states, one-hot
  // ------------------------------------------------------------
  typedef enum logic [7:0] {
    TDI_IDLE = 8'h01,
    TDI_DESC = 8'h02,
    TDI_EVAL = 8'h04,
    TDI_RD = 8'h08,
    TDI_OUT = 8'h10,
    TDI_OWN = 8'h20,
    TDI_DRAIN = 8'h40,
    TDI_RXAB = 8'h80
  } tdi_state_t;

  // Memory command toward the system bus
  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } tdi_mem_cmd_t;

  // One beat toward the endpoint FIFO
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
    logic zlp;
  } tdi_beat_t;

endpackage

// >>> tb/tb_tdi_engine.sv
`timescale 1ns/1ps
`include "tdi_defines.svh"
module tb_tdi_engine;
  logic pclk, presetn, psel, penable, pwrite, tx_ready, rx_drop;
  logic [11:0] paddr;
  logic [31:0] pwdata, rx_desc_addr, rx_desc_ctrl, rd;
  wire [31:0] prdata, mem_rdata;
  wire pready, pslverr, irq, mem_ack, rx_stalled;
  tdi_pkg::tdi_mem_cmd_t mem_cmd;
  tdi_pkg::tdi_beat_t tx_beat;
  int fails, checked;
  logic [9:0] exp_q [$];
  logic [9:0] e;
  logic [31:0] chain [0:11];
  wire [9:0] beat_seen = {tx_beat.zlp, tx_beat.last, tx_beat.data};

  tdi_engine i_tdi_engine (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .tx_beat(tx_beat), .tx_ready(tx_ready), .rx_drop(rx_drop),
    .rx_desc_addr(rx_desc_addr), .rx_desc_ctrl(rx_desc_ctrl),
    .rx_stalled(rx_stalled));
  tdi_mem_model i_mem (.pclk(pclk), .presetn(presetn), .mem_cmd(mem_cmd),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // One APB transfer, held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  // Bounded poll until a bit of a register is set
  task automatic poll(input logic [11:0] a, input logic [31:0] m);
    int n;
    n = 0;
    rd = 32'h0;
    while ((rd & m) == 32'h0 && n < 500)
    begin
      apb(1'b0, a, 32'h0);
      n++;
    end
    if ((rd & m) == 32'h0)
      fails++;
  endtask
  task automatic drop(input logic [31:0] a, input logic [31:0] c);
    @(posedge pclk);
    rx_drop <= 1'b1;
    rx_desc_addr <= a;
    rx_desc_ctrl <= c;
    @(posedge pclk);
    rx_drop <= 1'b0;
    @(negedge pclk);
  endtask
  function automatic logic [7:0] byte_at(input logic [9:0] a);
    return i_mem.mem[a[9:2]][8*a[1:0]+:8];
  endfunction

  // -------------------------------------------------------------
  // Stream watcher and far-side stalls
  // -------------------------------------------------------------
  always @(posedge pclk)
    tx_ready <= ($urandom_range(0, 3) != 0);
  always @(posedge pclk)
    if (tx_beat.valid && tx_ready)
    begin
      e = exp_q.size() ? exp_q.pop_front() : 10'h2ff;
      if (e[9])
        check(32'(beat_seen[9:8]), 32'(e[9:8]));
      else
        check(32'(beat_seen), 32'(e));
    end
  initial
  begin
    repeat (20000) @(posedge pclk);
    fails++;
    give_verdict();
  end

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {rx_drop, rx_desc_addr, rx_desc_ctrl} = '0;
    fails = 0;
    checked = 0;
    void'($urandom(14535));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`TDI_OFS_MASK, 32'h0);
    rdchk(`TDI_OFS_RXCNT, 32'h0);
    rdchk(12'h040, 32'h0);
    // Chain: two-buffer packet cut short, then a zero-length packet
    for (int i = 64; i < 76; i++)
      i_mem.mem[i] = $urandom;
    chain = '{32'h50, 32'h100, 32'h0002_0005, 32'haa00_0007,
              32'h60, 32'h120, 32'h0000_0004, 32'h4020_0000,
              32'h0, 32'h140, 32'h0000_0003, 32'he080_0000};
    for (int i = 0; i < 12; i++)
      i_mem.mem[16 + i] = chain[i];
    for (int i = 0; i < 7; i++)
      exp_q.push_back({1'b0, i == 6,
                       byte_at(10'(i < 5 ? 258 + i : 283 + i))});
    exp_q.push_back(10'h300);
    apb(1'b1, `TDI_OFS_CTRL, 32'h1);
    apb(1'b1, `TDI_OFS_HEAD, 32'h40);
    poll(12'h018, 32'h1);
    check(i_mem.mem[19], 32'h8a00_0007);
    check(i_mem.mem[23], 32'h4020_0000);
    check(i_mem.mem[27], 32'hd080_0000);
    check(32'(exp_q.size()), 32'h0);
    rdchk(`TDI_OFS_HEAD, 32'h0);
    // Interrupt: masked, unmasked, cleared bit by bit
    rdchk(`TDI_OFS_STAT, 32'h3);
    check(32'(irq), 32'h0);
    apb(1'b1, `TDI_OFS_MASK, 32'h3);
    @(negedge pclk);
    check(32'(irq), 32'h1);
    apb(1'b1, `TDI_OFS_STAT, 32'h1);
    @(negedge pclk);
    check(32'(irq), 32'h1);
    apb(1'b1, `TDI_OFS_STAT, 32'h2);
    @(negedge pclk);
    check(32'(irq), 32'h0);
    // Receive drop: ignored at count zero, then abort and refill
    drop(32'h80, 32'h8000_0000);
    check(32'(rx_stalled), 32'h0);
    i_mem.mem[35] = 32'h8000_0000;
    apb(1'b1, `TDI_OFS_RXCNT, 32'h2);
    rdchk(`TDI_OFS_RXCNT, 32'h2);
    drop(32'h80, 32'h8000_0000);
    check(32'(rx_stalled), 32'h1);
    poll(`TDI_OFS_STAT, 32'h4);
    poll(12'h018, 32'h1);
    check(i_mem.mem[35], 32'h8008_0000);
    rdchk(`TDI_OFS_RXCNT, 32'h0001_0000);
    check(32'(irq), 32'h0);
    apb(1'b1, `TDI_OFS_MASK, 32'h4);
    @(negedge pclk);
    check(32'(irq), 32'h1);
    apb(1'b1, `TDI_OFS_RXCNT, 32'h1);
    @(negedge pclk);
    check(32'(rx_stalled), 32'h0);
    rdchk(`TDI_OFS_RXCNT, 32'h1);
    apb(1'b1, `TDI_OFS_STAT, 32'h4);
    @(negedge pclk);
    check(32'(irq), 32'h0);
    give_verdict();
  end
endmodule

// >>> tb/tdi_engine_assertions.sv
`timescale 1ns/1ps
module tdi_engine_assertions (
  // Clock, reset and APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Memory, stream and receive side
  input tdi_pkg::tdi_mem_cmd_t mem_cmd,
  input wire logic mem_ack,
  input tdi_pkg::tdi_beat_t tx_beat,
  input wire logic tx_ready,
  input wire logic rx_drop,
  input wire logic rx_stalled
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase qualifier
  wire acc = psel && penable;
  chk_apb_answer: assert property (
    acc |-> pready && pslverr == (paddr >= 12'h01c))
    else $error("apb answer wrong");
  chk_req_held: assert property (
    mem_cmd.req && !mem_ack |=> mem_cmd.req && $stable(mem_cmd))
    else $error("memory request moved before ack");
  chk_beat_held: assert property (
    tx_beat.valid && !tx_ready |=> tx_beat.valid && $stable(tx_beat))
    else $error("beat moved before taken");
  chk_beat_gap: assert property (
    tx_beat.valid && tx_ready |=> !tx_beat.valid)
    else $error("beats back to back");
  chk_zlp_last: assert property (
    tx_beat.valid && tx_beat.zlp |-> tx_beat.last)
    else $error("zero length beat not last");
  chk_zlp_nofetch: assert property (
    tx_beat.valid && tx_beat.zlp |-> !mem_cmd.req)
    else $error("fetch during zero length beat");
  chk_stall_cause: assert property (
    $rose(rx_stalled) |-> $past(rx_drop))
    else $error("stall without drop");
  chk_stall_hold: assert property (
    $fell(rx_stalled) |-> $past(acc && pwrite && paddr == 12'h010))
    else $error("stall left without refill");
  chk_wb_aligned: assert property (
    mem_cmd.req && mem_cmd.we |-> mem_cmd.addr[1:0] == 2'b00)
    else $error("unaligned writeback");
  // A drained first descriptor must also show the packet handed back
  chk_wb_owner: assert property (
    mem_cmd.req && mem_cmd.we && mem_cmd.wdata[31] && mem_cmd.wdata[28]
    |-> !mem_cmd.wdata[29])
    else $error("owner left set on drained first descriptor");
endmodule

bind tdi_engine tdi_engine_assertions i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .mem_cmd(mem_cmd), .mem_ack(mem_ack),
  .tx_beat(tx_beat), .tx_ready(tx_ready), .rx_drop(rx_drop),
  .rx_stalled(rx_stalled));

// >>> tb/tdi_mem_model.sv
`timescale 1ns/1ps
module tdi_mem_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Engine memory port
  input tdi_pkg::tdi_mem_cmd_t mem_cmd,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  // Word store, filled by the bench with chains and buffers
  logic [31:0] mem [0:255];
  logic [1:0] wait_cnt;
  wire [7:0] idx = mem_cmd.addr[9:2];
  // Random stall; data off the bus is inverted, never the stale word
  assign mem_ack = mem_cmd.req && wait_cnt == 2'h0;
  assign mem_rdata = mem_ack ? mem[idx] : ~mem[idx];
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      wait_cnt <= 2'h0;
    else if (mem_ack)
    begin
      wait_cnt <= 2'($urandom_range(0, 3));
      if (mem_cmd.we)
        mem[idx] <= mem_cmd.wdata;
    end
    else if (mem_cmd.req)
      wait_cnt <= wait_cnt - 2'h1;
endmodule
